// File: core/pcg_clock_gating.sv
// Peripheral clock-gating control: APB registers, power-state set selection, access faults
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RULE1] A unit gets its clock while its enable bit is one, none while zero.
// [RULE2] Access to an unclocked unit answers with a bus fault.
// [RULE3] All enable bits are zero after reset; every unit starts unclocked.
// [RULE4] Separate run, sleep and deep-sleep sets; the one for the power state applies.
// [RULE5] Sleep and deep-sleep sets apply only while the auto-gating bit is set.
// [RULE6] Registers sit in the control region at 0x400FE000; comm/timer run register at 0x104.
// [RULE7] Deep-sleep register 0x120 bit 3 enables the watchdog clock in deep sleep.
// [RULE8] Run comm/timer register bits 18, 17, 16 enable timers 2, 1, 0.
// [RULE9] Run comm/timer register bit 12 enables the two-wire unit.
// [RULE10] Run comm/timer register bit 4 enables the synchronous serial unit.
// [RULE11] Run comm/timer register bits 1 and 0 enable async serial units 1 and 0.
// [RULE12] Watchdog deep-sleep register bits 31:4 and 2:0 read zero, are read-only.
// [RULE13] Comm/timer run register bits 15:13, 11:5, 3:2 read zero, are read-only.
// [RULE14] Writes to read-only bits change nothing; writable bits update normally.
module pcg_clock_gating
   import pcg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Power state from the core, same clock
   input wire logic sleepState,
   input wire logic deepSleepState,
   // Peripheral access check
   input wire pcg_periph_req_s periphReq,
   output pcg_periph_rsp_s periphRsp,
   // Clock enables for the unit gating cells
   output pcg_unit_t unitClkEn,
   output pcg_power_e powerState
);

   // ==========================================================================
   // State
   pcg_state_s st;
   pcg_state_s next_st;
   pcg_reg_e sel;
   logic hit;
   pcg_periph_rsp_s chkRsp;
   logic setupPhase;
   logic accessWrite;
   logic autoSleep;
   pcg_unit_t runVec;
   pcg_unit_t sleepVec;
   pcg_unit_t deepVec;
   logic [31:0] readVal;

   pcg_apb_decode u_decode (
      .paddr(paddr),
      .sel(sel),
      .hit(hit)
   );

   pcg_access_check u_check (
      .req(periphReq),
      .clkEn(st.clkEn),
      .rsp(chkRsp)
   );

   // ==========================================================================
   // Next-state logic
   always_comb begin
      next_st = st;
      setupPhase = psel && !penable;
      accessWrite = psel && penable && st.pready && pwrite && !st.pslverr;
      autoSleep = st.runCfg[PCG_BIT_AUTO_SLEEP];
      runVec = pcg_gate_map(st.runGate0, st.runGate1); // see [RULE8] [RULE9] [RULE10] [RULE11]
      sleepVec = pcg_gate_map(st.sleepGate0, st.sleepGate1);
      deepVec = pcg_gate_map(st.deepGate0, st.deepGate1); // see [RULE7]

      // Reserved bits are never stored, so they read back as zero
      case (sel)
         PCG_SEL_RUN0: readVal = st.runGate0;
         PCG_SEL_RUN1: readVal = st.runGate1; // see [RULE6] [RULE13]
         PCG_SEL_SLEEP0: readVal = st.sleepGate0;
         PCG_SEL_SLEEP1: readVal = st.sleepGate1;
         PCG_SEL_DEEP0: readVal = st.deepGate0; // see [RULE12]
         PCG_SEL_DEEP1: readVal = st.deepGate1;
         PCG_SEL_CFG: readVal = st.runCfg;
         default: readVal = 32'h0000_0000;
      endcase

      // Answer is prepared in the setup cycle, so every access has no wait state
      next_st.pready = setupPhase;
      next_st.pslverr = setupPhase && !hit;
      next_st.prdata = (setupPhase && !pwrite) ? readVal : 32'h0000_0000;

      // Writes land only on the completing edge; masks drop read-only bits
      if (accessWrite) begin
         case (sel)
            PCG_SEL_RUN0: begin
               next_st.runGate0 = pcg_apply_strobe(st.runGate0, pwdata, pstrb, PCG_MASK_GATE0);
            end
            PCG_SEL_RUN1: begin
               // see [RULE14]
               next_st.runGate1 = pcg_apply_strobe(st.runGate1, pwdata, pstrb, PCG_MASK_GATE1);
            end
            PCG_SEL_SLEEP0: begin
               next_st.sleepGate0 = pcg_apply_strobe(st.sleepGate0, pwdata, pstrb,
                  PCG_MASK_GATE0);
            end
            PCG_SEL_SLEEP1: begin
               next_st.sleepGate1 = pcg_apply_strobe(st.sleepGate1, pwdata, pstrb,
                  PCG_MASK_GATE1);
            end
            PCG_SEL_DEEP0: begin
               // see [RULE12]
               next_st.deepGate0 = pcg_apply_strobe(st.deepGate0, pwdata, pstrb, PCG_MASK_GATE0);
            end
            PCG_SEL_DEEP1: begin
               next_st.deepGate1 = pcg_apply_strobe(st.deepGate1, pwdata, pstrb, PCG_MASK_GATE1);
            end
            PCG_SEL_CFG: begin
               next_st.runCfg = pcg_apply_strobe(st.runCfg, pwdata, pstrb, PCG_MASK_RUN_CFG);
            end
            default: begin
               next_st.runCfg = st.runCfg;
            end
         endcase
      end

      // Deep sleep outranks sleep when the core reports both
      if (deepSleepState) begin
         next_st.power = PCG_PWR_DEEP;
      end else if (sleepState) begin
         next_st.power = PCG_PWR_SLEEP;
      end else begin
         next_st.power = PCG_PWR_RUN;
      end

      // Without auto-gating the run set stays in force in every power state
      case (st.power)
         PCG_PWR_SLEEP: next_st.clkEn = autoSleep ? sleepVec : runVec; // see [RULE4] [RULE5]
         PCG_PWR_DEEP: next_st.clkEn = autoSleep ? deepVec : runVec; // see [RULE4] [RULE5]
         default: next_st.clkEn = runVec; // see [RULE1]
      endcase

      next_st.rsp = chkRsp; // see [RULE2]
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= PCG_STATE_RST; // see [RULE3]
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign periphRsp = st.rsp;
   assign unitClkEn = st.clkEn;
   assign powerState = st.power;

   // ==========================================================================
   // Assertions
   logic everWritten;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         everWritten <= 1'b0;
      end else if (accessWrite) begin
         everWritten <= 1'b1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   property p_run_enable_reaches_clock;
      (accessWrite && sel == PCG_SEL_RUN1 && pstrb[0] && pwdata[PCG_BIT_ASYNC_ZERO]
         && st.power == PCG_PWR_RUN && !sleepState && !deepSleepState)
         |=> ##1 (unitClkEn[PCG_UNIT_ASYNC_ZERO] || powerState != PCG_PWR_RUN);
   endproperty
   a_run_enable_reaches_clock: assert property (p_run_enable_reaches_clock) // see [RULE1]
      else $error("run enable did not reach the unit clock");

   property p_unclocked_faults;
      (periphReq.valid && !unitClkEn[periphReq.unit])
         |=> (periphRsp.fault && !periphRsp.grant);
   endproperty
   a_unclocked_faults: assert property (p_unclocked_faults) // see [RULE2]
      else $error("access to unclocked unit was not faulted");

   property p_clocked_granted;
      (periphReq.valid && unitClkEn[periphReq.unit]) |=> (periphRsp.grant && !periphRsp.fault);
   endproperty
   a_clocked_granted: assert property (p_clocked_granted) // see [RULE2]
      else $error("access to clocked unit was refused");

   property p_quiet_until_write;
      !everWritten |-> (unitClkEn == '0 && st.runCfg == PCG_RUN_CFG_RST);
   endproperty
   a_quiet_until_write: assert property (p_quiet_until_write) // see [RULE3]
      else $error("clock enabled before any register write");

   property p_deep_set_applied;
      (st.power == PCG_PWR_DEEP && autoSleep) |=> (unitClkEn == $past(deepVec));
   endproperty
   a_deep_set_applied: assert property (p_deep_set_applied) // see [RULE4]
      else $error("deep-sleep set not applied in deep sleep");

   property p_sleep_set_applied;
      (st.power == PCG_PWR_SLEEP && autoSleep) |=> (unitClkEn == $past(sleepVec));
   endproperty
   a_sleep_set_applied: assert property (p_sleep_set_applied) // see [RULE4]
      else $error("sleep set not applied in sleep");

   property p_run_set_without_auto;
      !autoSleep |=> (unitClkEn == $past(runVec));
   endproperty
   a_run_set_without_auto: assert property (p_run_set_without_auto) // see [RULE5]
      else $error("low-power set used without auto-gating");

   property p_comm_timer_read;
      (setupPhase && !pwrite && paddr == (PCG_BASE_ADDR | 32'(PCG_OFS_RUN_GATE1)))
         |=> (pready && !pslverr && prdata == $past(st.runGate1));
   endproperty
   a_comm_timer_read: assert property (p_comm_timer_read) // see [RULE6]
      else $error("comm/timer run register not readable at its address");

   property p_watchdog_deep_write;
      (accessWrite && sel == PCG_SEL_DEEP0 && pstrb[0])
         |=> (st.deepGate0[PCG_BIT_WATCHDOG] == $past(pwdata[PCG_BIT_WATCHDOG]));
   endproperty
   a_watchdog_deep_write: assert property (p_watchdog_deep_write) // see [RULE7]
      else $error("watchdog deep-sleep enable not written");

   property p_timer_bits_write;
      (accessWrite && sel == PCG_SEL_RUN1 && pstrb[2])
         |=> (st.runGate1[18:16] == $past(pwdata[18:16]) && st.runGate1[31:19] == '0);
   endproperty
   a_timer_bits_write: assert property (p_timer_bits_write) // see [RULE8]
      else $error("timer enables not written");

   property p_two_wire_write;
      (accessWrite && sel == PCG_SEL_RUN1 && pstrb[1])
         |=> (st.runGate1[PCG_BIT_TWO_WIRE] == $past(pwdata[PCG_BIT_TWO_WIRE]));
   endproperty
   a_two_wire_write: assert property (p_two_wire_write) // see [RULE9]
      else $error("two-wire enable not written");

   property p_sync_serial_write;
      (accessWrite && sel == PCG_SEL_RUN1 && pstrb[0])
         |=> (st.runGate1[PCG_BIT_SYNC_SERIAL] == $past(pwdata[PCG_BIT_SYNC_SERIAL]));
   endproperty
   a_sync_serial_write: assert property (p_sync_serial_write) // see [RULE10]
      else $error("sync serial enable not written");

   property p_async_write;
      (accessWrite && sel == PCG_SEL_RUN1 && pstrb[0])
         |=> (st.runGate1[1:0] == $past(pwdata[1:0]));
   endproperty
   a_async_write: assert property (p_async_write) // see [RULE11]
      else $error("async serial enables not written");

   property p_watchdog_reserved_zero;
      (setupPhase && !pwrite && sel == PCG_SEL_DEEP0)
         |=> ((prdata & ~PCG_MASK_GATE0) == 32'h0000_0000);
   endproperty
   a_watchdog_reserved_zero: assert property (p_watchdog_reserved_zero) // see [RULE12]
      else $error("deep-sleep watchdog register reserved bits not zero");

   property p_comm_reserved_zero;
      (setupPhase && !pwrite && sel == PCG_SEL_RUN1)
         |=> ((prdata & ~PCG_MASK_GATE1) == 32'h0000_0000);
   endproperty
   a_comm_reserved_zero: assert property (p_comm_reserved_zero) // see [RULE13]
      else $error("comm/timer register reserved bits not zero");

   property p_reserved_write_harmless;
      (accessWrite && sel == PCG_SEL_RUN1
         && ((pwdata & PCG_MASK_GATE1) == st.runGate1) && pstrb == 4'hF)
         |=> $stable(st.runGate1) ##1 $stable(unitClkEn) || st.power != PCG_PWR_RUN;
   endproperty
   a_reserved_write_harmless: assert property (p_reserved_write_harmless) // see [RULE14]
      else $error("write to read-only bits changed state");

   property p_ready_one_cycle;
      pready |=> !pready;
   endproperty
   a_ready_one_cycle: assert property (p_ready_one_cycle) // see [RULE6]
      else $error("ready held longer than one cycle");

   property p_unmapped_refused;
      (setupPhase && !hit) |=> (pready && pslverr && prdata == 32'h0000_0000);
   endproperty
   a_unmapped_refused: assert property (p_unmapped_refused) // see [RULE6]
      else $error("unmapped access not refused");

   property p_refused_write_ignored;
      (psel && penable && pwrite && st.pready && st.pslverr)
         |=> ($stable(st.runGate1) && $stable(st.deepGate0) && $stable(st.runCfg));
   endproperty
   a_refused_write_ignored: assert property (p_refused_write_ignored) // see [RULE6]
      else $error("refused write changed a register");

   property p_gates_change_only_by_write;
      !accessWrite |=> ($stable(st.runGate1) && $stable(st.deepGate0) && $stable(st.runCfg));
   endproperty
   a_gates_change_only_by_write: assert property (p_gates_change_only_by_write) // see [RULE3]
      else $error("gating register changed without a write");

   property p_deep_state_wins;
      deepSleepState |=> (powerState == PCG_PWR_DEEP);
   endproperty
   a_deep_state_wins: assert property (p_deep_state_wins) // see [RULE4]
      else $error("deep sleep not taken as power state");

   property p_sleep_state_taken;
      (sleepState && !deepSleepState) |=> (powerState == PCG_PWR_SLEEP);
   endproperty
   a_sleep_state_taken: assert property (p_sleep_state_taken) // see [RULE4]
      else $error("sleep not taken as power state");

   property p_idle_no_answer;
      !periphReq.valid |=> (!periphRsp.grant && !periphRsp.fault);
   endproperty
   a_idle_no_answer: assert property (p_idle_no_answer) // see [RULE2]
      else $error("peripheral answer without a request");

   cover property (st.power == PCG_PWR_DEEP && autoSleep && unitClkEn[PCG_UNIT_WATCHDOG]);
   cover property (periphRsp.fault);
   cover property (pready && pslverr);
   cover property (st.power == PCG_PWR_SLEEP && autoSleep && unitClkEn != runVec);

endmodule
`default_nettype wire

// File: core/pcg_pkg.sv
// Package: register map, field layout, types and helpers of the clock-gating block
package pcg_pkg;

   // ==========================================================================
   // Register map (byte addresses inside the system-control region)
   localparam logic [31:0] PCG_BASE_ADDR = 32'h400F_E000;
   localparam logic [11:0] PCG_OFS_RUN_CFG = 12'h060;
   localparam logic [11:0] PCG_OFS_RUN_GATE0 = 12'h100;
   localparam logic [11:0] PCG_OFS_RUN_GATE1 = 12'h104;
   localparam logic [11:0] PCG_OFS_SLEEP_GATE0 = 12'h110;
   localparam logic [11:0] PCG_OFS_SLEEP_GATE1 = 12'h114;
   localparam logic [11:0] PCG_OFS_DEEP_GATE0 = 12'h120;
   localparam logic [11:0] PCG_OFS_DEEP_GATE1 = 12'h124;

   // ==========================================================================
   // Field layout
   localparam int PCG_BIT_WATCHDOG = 3;
   localparam int PCG_BIT_GP_TWO = 18;
   localparam int PCG_BIT_GP_ONE = 17;
   localparam int PCG_BIT_GP_ZERO = 16;
   localparam int PCG_BIT_TWO_WIRE = 12;
   localparam int PCG_BIT_SYNC_SERIAL = 4;
   localparam int PCG_BIT_ASYNC_ONE = 1;
   localparam int PCG_BIT_ASYNC_ZERO = 0;
   localparam int PCG_BIT_AUTO_SLEEP = 27;
   localparam logic [31:0] PCG_MASK_GATE0 = 32'h0000_0008;
   localparam logic [31:0] PCG_MASK_GATE1 = 32'h0007_1013;
   localparam logic [31:0] PCG_MASK_RUN_CFG = 32'h0800_0000;

   // ==========================================================================
   // Values after reset
   localparam logic [31:0] PCG_GATE_RST = 32'h0000_0000;
   localparam logic [31:0] PCG_RUN_CFG_RST = 32'h0000_0000;

   // ==========================================================================
   // Types
   localparam int PCG_NUM_UNITS = 8;
   typedef logic [PCG_NUM_UNITS-1:0] pcg_unit_t;

   typedef enum logic [2:0] {
      PCG_UNIT_WATCHDOG = 3'b000,
      PCG_UNIT_GP_ZERO = 3'b001,
      PCG_UNIT_GP_ONE = 3'b010,
      PCG_UNIT_GP_TWO = 3'b011,
      PCG_UNIT_TWO_WIRE = 3'b100,
      PCG_UNIT_SYNC_SERIAL = 3'b101,
      PCG_UNIT_ASYNC_ZERO = 3'b110,
      PCG_UNIT_ASYNC_ONE = 3'b111
   } pcg_unit_e;

   typedef enum logic [1:0] {
      PCG_PWR_RUN = 2'b00,
      PCG_PWR_SLEEP = 2'b01,
      PCG_PWR_DEEP = 2'b10
   } pcg_power_e;

   typedef enum logic [2:0] {
      PCG_SEL_NONE = 3'b000,
      PCG_SEL_RUN0 = 3'b001,
      PCG_SEL_RUN1 = 3'b010,
      PCG_SEL_SLEEP0 = 3'b011,
      PCG_SEL_SLEEP1 = 3'b100,
      PCG_SEL_DEEP0 = 3'b101,
      PCG_SEL_DEEP1 = 3'b110,
      PCG_SEL_CFG = 3'b111
   } pcg_reg_e;

   typedef struct packed {
      logic valid;
      logic write;
      pcg_unit_e unit;
   } pcg_periph_req_s;

   typedef struct packed {
      logic grant;
      logic fault;
   } pcg_periph_rsp_s;

   typedef struct packed {
      logic [31:0] runGate0;
      logic [31:0] runGate1;
      logic [31:0] sleepGate0;
      logic [31:0] sleepGate1;
      logic [31:0] deepGate0;
      logic [31:0] deepGate1;
      logic [31:0] runCfg;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      pcg_power_e power;
      pcg_unit_t clkEn;
      pcg_periph_rsp_s rsp;
   } pcg_state_s;

   localparam pcg_state_s PCG_STATE_RST = '{
      runGate0: PCG_GATE_RST,
      runGate1: PCG_GATE_RST,
      sleepGate0: PCG_GATE_RST,
      sleepGate1: PCG_GATE_RST,
      deepGate0: PCG_GATE_RST,
      deepGate1: PCG_GATE_RST,
      runCfg: PCG_RUN_CFG_RST,
      prdata: 32'h0000_0000,
      pready: 1'b0,
      pslverr: 1'b0,
      power: PCG_PWR_RUN,
      clkEn: 8'h00,
      rsp: 2'b00
   };

   // ==========================================================================
   // Helpers
   function automatic pcg_unit_t pcg_gate_map(input logic [31:0] g0, input logic [31:0] g1);
      pcg_unit_t v;
      v = '0;
      v[PCG_UNIT_WATCHDOG] = g0[PCG_BIT_WATCHDOG];
      v[PCG_UNIT_GP_ZERO] = g1[PCG_BIT_GP_ZERO];
      v[PCG_UNIT_GP_ONE] = g1[PCG_BIT_GP_ONE];
      v[PCG_UNIT_GP_TWO] = g1[PCG_BIT_GP_TWO];
      v[PCG_UNIT_TWO_WIRE] = g1[PCG_BIT_TWO_WIRE];
      v[PCG_UNIT_SYNC_SERIAL] = g1[PCG_BIT_SYNC_SERIAL];
      v[PCG_UNIT_ASYNC_ZERO] = g1[PCG_BIT_ASYNC_ZERO];
      v[PCG_UNIT_ASYNC_ONE] = g1[PCG_BIT_ASYNC_ONE];
      return v;
   endfunction

   // Byte-lane merge; bits outside the mask always come out zero
   function automatic logic [31:0] pcg_apply_strobe(input logic [31:0] old,
         input logic [31:0] wdata, input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = wdata[8*i +: 8];
         end
      end
      return r & mask;
   endfunction

endpackage

// File: core/pcg_apb_decode.sv
// Address decoder of the clock-gating register window
`timescale 1ns/10ps
`default_nettype none

module pcg_apb_decode
   import pcg_pkg::*;
(
   // Bus address
   input wire logic [31:0] paddr,
   // Decode result
   output pcg_reg_e sel,
   output var logic hit
);

   always_comb begin
      sel = PCG_SEL_NONE;
      if (paddr[31:12] == PCG_BASE_ADDR[31:12] && paddr[1:0] == 2'b00) begin
         case (paddr[11:0])
            PCG_OFS_RUN_GATE0: sel = PCG_SEL_RUN0;
            PCG_OFS_RUN_GATE1: sel = PCG_SEL_RUN1;
            PCG_OFS_SLEEP_GATE0: sel = PCG_SEL_SLEEP0;
            PCG_OFS_SLEEP_GATE1: sel = PCG_SEL_SLEEP1;
            PCG_OFS_DEEP_GATE0: sel = PCG_SEL_DEEP0;
            PCG_OFS_DEEP_GATE1: sel = PCG_SEL_DEEP1;
            PCG_OFS_RUN_CFG: sel = PCG_SEL_CFG;
            default: sel = PCG_SEL_NONE;
         endcase
      end
      hit = (sel != PCG_SEL_NONE);
   end

endmodule
`default_nettype wire

// File: core/pcg_access_check.sv
// Access check of peripheral requests against the live clock enables
`timescale 1ns/10ps
`default_nettype none

module pcg_access_check
   import pcg_pkg::*;
(
   // Request from the peripheral bus fabric
   input wire pcg_periph_req_s req,
   // Clock enables in force
   input wire pcg_unit_t clkEn,
   // Verdict
   output pcg_periph_rsp_s rsp
);

   always_comb begin
      rsp.grant = req.valid && clkEn[req.unit];
      // An unclocked unit cannot answer, so the access faults instead
      rsp.fault = req.valid && !clkEn[req.unit]; // see [RULE2]
   end

endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench of the peripheral clock-gating block
`timescale 1ns/10ps
`default_nettype none

module tb
   import pcg_pkg::*;
;
   // ==========================================================================
   // Stimulus and observation
   typedef struct packed {
      logic [11:0] ofs;
      logic [31:0] wdata;
      logic [31:0] rdExp;
   } pcg_tb_row_s;

   logic clk;
   logic rst_b;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sleepState;
   logic deepSleepState;
   pcg_periph_req_s periphReq;
   pcg_periph_rsp_s periphRsp;
   pcg_unit_t unitClkEn;
   pcg_power_e powerState;
   int nMismatch;
   int checked;
   int cycles;
   logic [31:0] rd;
   logic err;
   pcg_tb_row_s rows [7];

   pcg_clock_gating dut (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleepState(sleepState), .deepSleepState(deepSleepState),
      .periphReq(periphReq), .periphRsp(periphRsp), .unitClkEn(unitClkEn),
      .powerState(powerState)
   );

   initial begin
      clk = 1'b0;
   end
   always #4 clk = ~clk;

   // ==========================================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checked, nMismatch);
      if (nMismatch == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Request is held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic periph(input pcg_unit_e u, input logic expGrant);
      @(posedge clk);
      periphReq <= '{valid: 1'b1, write: 1'b0, unit: u};
      @(posedge clk);
      periphReq <= '{valid: 1'b0, write: 1'b0, unit: PCG_UNIT_WATCHDOG};
      @(posedge clk);
      check({30'd0, periphRsp}, {30'd0, expGrant, ~expGrant});
   endtask

   // Gating changes reach the enables two cycles after the power inputs move
   task automatic settle_en(input logic [7:0] exp);
      repeat (3) @(posedge clk);
      check({24'd0, unitClkEn}, {24'd0, exp});
   endtask

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles > 5000) begin
         nMismatch++;
         close_out();
      end
   end

   // ==========================================================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      sleepState = 1'b0;
      deepSleepState = 1'b0;
      periphReq = '0;
      nMismatch = 0;
      checked = 0;
      cycles = 0;
      rows[0] = '{PCG_OFS_RUN_GATE0, 32'hFFFF_FFFF, 32'h0000_0008};
      rows[1] = '{PCG_OFS_RUN_GATE1, 32'hFFFF_FFFF, 32'h0007_1013};
      rows[2] = '{PCG_OFS_SLEEP_GATE0, 32'hFFFF_FFFF, 32'h0000_0008};
      rows[3] = '{PCG_OFS_SLEEP_GATE1, 32'hFFFF_FFFF, 32'h0007_1013};
      rows[4] = '{PCG_OFS_DEEP_GATE0, 32'hFFFF_FFFF, 32'h0000_0008};
      rows[5] = '{PCG_OFS_DEEP_GATE1, 32'hFFFF_FFFF, 32'h0007_1013};
      rows[6] = '{PCG_OFS_RUN_CFG, 32'hFFFF_FFFF, 32'h0800_0000};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      check({24'd0, unitClkEn}, 32'h0000_0000);

      // Every register: reset value, then all ones written and masked back
      foreach (rows[i]) begin
         apb(1'b0, PCG_BASE_ADDR + {20'd0, rows[i].ofs}, 32'h0, 4'hF, rd, err);
         check(rd, 32'h0000_0000);
         apb(1'b1, PCG_BASE_ADDR + {20'd0, rows[i].ofs}, rows[i].wdata, 4'hF, rd, err);
         check({31'd0, err}, 32'h0);
         apb(1'b0, PCG_BASE_ADDR + {20'd0, rows[i].ofs}, 32'h0, 4'hF, rd, err);
         check(rd, rows[i].rdExp);
      end
      $display("Register table test done");

      // Run mode, all enables on, every unit answers
      settle_en(8'hFF);
      for (int u = 0; u < PCG_NUM_UNITS; u++) begin
         periph(pcg_unit_e'(u[2:0]), 1'b1);
      end
      // Lane 0 only: sync serial and async one go off, upper lanes keep
      apb(1'b1, PCG_BASE_ADDR + 32'h104, 32'hFFFF_FF01, 4'h1, rd, err);
      apb(1'b0, PCG_BASE_ADDR + 32'h104, 32'h0, 4'hF, rd, err);
      check(rd, 32'h0007_1001);
      settle_en(8'h5F);
      periph(PCG_UNIT_SYNC_SERIAL, 1'b0);
      periph(PCG_UNIT_ASYNC_ONE, 1'b0);
      periph(PCG_UNIT_ASYNC_ZERO, 1'b1);
      $display("Run gating test done");

      // Deep sleep with auto gating: only the watchdog keeps its clock;
      // sleep is reported too, so deep sleep must outrank it
      apb(1'b1, PCG_BASE_ADDR + 32'h124, 32'h0000_0000, 4'hF, rd, err);
      @(posedge clk);
      deepSleepState <= 1'b1;
      sleepState <= 1'b1;
      settle_en(8'h01);
      check({30'd0, powerState}, {30'd0, PCG_PWR_DEEP});
      periph(PCG_UNIT_GP_ZERO, 1'b0);
      periph(PCG_UNIT_WATCHDOG, 1'b1);
      // Ones on every reserved bit must read back as zero
      apb(1'b1, PCG_BASE_ADDR + 32'h120, 32'hFFFF_FFF7, 4'hF, rd, err);
      apb(1'b0, PCG_BASE_ADDR + 32'h120, 32'h0, 4'hF, rd, err);
      check(rd, 32'h0000_0000);
      settle_en(8'h00);
      // Sleep uses the sleep set, all on
      @(posedge clk);
      deepSleepState <= 1'b0;
      settle_en(8'hFF);
      check({30'd0, powerState}, {30'd0, PCG_PWR_SLEEP});
      // Auto gating off: the run set governs sleep as well
      apb(1'b1, PCG_BASE_ADDR + {20'd0, PCG_OFS_RUN_CFG}, 32'h0, 4'hF, rd, err);
      settle_en(8'h5F);
      @(posedge clk);
      sleepState <= 1'b0;
      $display("Power state test done");

      // Unmapped and unaligned accesses are refused and change nothing
      apb(1'b0, 32'h4000_0000, 32'h0, 4'hF, rd, err);
      check({31'd0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, PCG_BASE_ADDR + 32'h106, 32'h0, 4'hF, rd, err);
      check({31'd0, err}, 32'h1);
      // Ones on read-only bits, writable bits as they stand: nothing moves
      apb(1'b1, PCG_BASE_ADDR + 32'h104, 32'hFFFF_FFED, 4'hF, rd, err);
      settle_en(8'h5F);
      apb(1'b0, PCG_BASE_ADDR + 32'h104, 32'h0, 4'hF, rd, err);
      check(rd, 32'h0007_1001);
      $display("Refusal test done");

      // Second reset in mid-run clears every enable
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      check({24'd0, unitClkEn}, 32'h0);
      check({30'd0, powerState}, 32'h0);
      rst_b <= 1'b1;
      apb(1'b0, PCG_BASE_ADDR + 32'h104, 32'h0, 4'hF, rd, err);
      check(rd, 32'h0);
      periph(PCG_UNIT_TWO_WIRE, 1'b0);
      $display("Reset test done");
      close_out();
   end
endmodule

`default_nettype wire
